// ==== src/ata_params.svh ====
// constants for the task-file command link and its two ends
`ifndef ATA_PARAMS_SVH
`define ATA_PARAMS_SVH
`define OP_CHKPWR_A 8'h98
`define OP_CHKPWR_B 8'he5
`define OP_ERASE 8'hc0
`define OP_DIAG 8'h90
`define OP_FLUSH 8'he7
`define OP_FORMAT 8'h50
`define DH_DRV_BIT 4
`define DH_LBA_BIT 6
`define DH_HEAD_MSB 3
`define SC_STANDBY 8'h00
`define SC_IDLE 8'hff
`define ERR_ABORT 8'h04
`define DIAG_SLAVE_NIB 4'h8
`define FILL_PATTERN 8'hff
`define SECTOR_WORDS 256
`define CLK_MHZ 50
`define T_DRQ_MAX_US 700
`define T_BSY_DROP_NS 400
`define CLK_PERIOD_NS 20
`define BUF_SETUP_CYC 16
`define TRACK_SECTORS 63
`define HOST_NOBSY_CYC 4
`define REG_CMD 8'h00
`define REG_SC 8'h04
`define REG_SN 8'h08
`define REG_CYL_LO 8'h0c
`define REG_CYL_HI 8'h10
`define REG_DH 8'h14
`define REG_CTRL 8'h18
`define REG_STATUS 8'h1c
`define REG_INT_STAT 8'h20
`define REG_INT_MASK 8'h24
`define CTRL_IRQDIS_BIT 1
`define EV_DONE 0
`define EV_ERROR 1
`define EV_REFUSED 2
`define EV_DEV_IRQ 3
`define EV_BITS 4
`endif

// ==== src/ata_pkg.sv ====
// types shared by both ends of the task-file command link
package ata_pkg;
  typedef enum logic [5:0] {
    D_IDLE = 6'b000001,
    D_DECODE = 6'b000010,
    D_SETUP = 6'b000100,
    D_XFER = 6'b001000,
    D_MEDIA = 6'b010000,
    D_FIN = 6'b100000
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_WAIT = 3'b010,
    H_DATA = 3'b100
  } host_state_t;
endpackage

// ==== src/ata_link_if.sv ====
// task-file link between host controller and drive command logic
`timescale 1ns/1ps
interface ata_link_if;
  logic cmd_wr;
  logic [7:0] cmd;
  logic [7:0] sc;
  logic [7:0] sn;
  logic [7:0] cyl_lo;
  logic [7:0] cyl_hi;
  logic [7:0] dh;
  logic irq_disable_bit;
  logic data_wr;
  logic [15:0] data;
  logic bsy;
  logic drdy;
  logic dsc;
  logic drq;
  logic df;
  logic err;
  logic intrq;
  logic [7:0] sc_rd;
  logic [7:0] err_rd;
  modport host (output cmd_wr, cmd, sc, sn, cyl_lo, cyl_hi, dh,
    irq_disable_bit, data_wr, data,
    input bsy, drdy, dsc, drq, df, err, intrq, sc_rd, err_rd);
  modport dev (input cmd_wr, cmd, sc, sn, cyl_lo, cyl_hi, dh,
    irq_disable_bit, data_wr, data,
    output bsy, drdy, dsc, drq, df, err, intrq, sc_rd, err_rd);
endinterface

// ==== src/cycle_timer.sv ====
// one-shot down counter, pulses done when the loaded count expires
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  output logic done_out
);
  logic [W-1:0] cnt_q;
  logic run_q;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (load_in) begin
        cnt_q <= value_in;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= W'(1)) begin
          run_q <= 1'b0;
          done_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule

// ==== src/ata_dev_end.sv ====
// drive-side command execution for the maintenance command group
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "ata_params.svh"
module ata_dev_end
  import ata_pkg::*;
#(
  parameter bit CACHE_FLUSH = 1'b1,
  parameter int DRQ_MAX_CYC = `T_DRQ_MAX_US * `CLK_MHZ,
  parameter int SETUP_CYC = `BUF_SETUP_CYC,
  parameter logic [8:0] TRACK_SECTORS = 9'(`TRACK_SECTORS),
  parameter logic [7:0] FILL = `FILL_PATTERN
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  ata_link_if.dev link,
  input wire logic is_slave_in,
  input wire logic standby_in,
  input wire logic slave_fail_in,
  input wire logic diag_done_in,
  input wire logic [3:0] diag_code_in,
  input wire logic erase_done_in,
  input wire logic erase_fault_in,
  input wire logic flush_done_in,
  input wire logic fmt_done_in,
  output logic diag_req_out,
  output logic erase_req_out,
  output logic flush_req_out,
  output logic fmt_req_out,
  output logic [27:0] lba_out,
  output logic [8:0] count_out,
  output logic [7:0] fill_out
);
  localparam int BSY_DROP_CYC = `T_BSY_DROP_NS / `CLK_PERIOD_NS;
  // bsy falls in the same cycle drq rises, far inside the allowed window
  localparam int SETUP_USE =
    (SETUP_CYC < DRQ_MAX_CYC) ? SETUP_CYC : DRQ_MAX_CYC;
  localparam int TW = $clog2(DRQ_MAX_CYC + 1);

  dev_state_t state_q;
  logic [7:0] cmd_q;
  logic [8:0] words_q;
  logic tmr_load;
  logic tmr_done;
  logic sel;
  logic is_chk;
  logic media_done;

  assign sel = (link.dh[`DH_DRV_BIT] == is_slave_in);
  assign is_chk = (link.cmd == `OP_CHKPWR_A) || (link.cmd == `OP_CHKPWR_B);
  assign tmr_load = (state_q == D_DECODE) && (cmd_q == `OP_FORMAT);

  always_comb begin
    case (cmd_q)
      `OP_ERASE: media_done = erase_done_in;
      `OP_DIAG: media_done = diag_done_in;
      `OP_FLUSH: media_done = flush_done_in;
      `OP_FORMAT: media_done = fmt_done_in;
      default: media_done = 1'b1;
    endcase
  end

  cycle_timer #(
    .W(TW)
  ) u_setup (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .load_in(tmr_load),
    .value_in(TW'(SETUP_USE)),
    .done_out(tmr_done)
  );

  // command sequencing and handshake bits
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_q <= D_IDLE;
      cmd_q <= 8'h00;
      words_q <= 9'h000;
      link.bsy <= 1'b0;
      link.drq <= 1'b0;
    end else begin
      case (state_q)
        D_IDLE: begin
          // diagnostic runs whatever the drive bit says
          if (link.cmd_wr && (sel || link.cmd == `OP_DIAG)) begin
            cmd_q <= is_chk ? `OP_CHKPWR_A : link.cmd;
            link.bsy <= 1'b1;
            state_q <= D_DECODE;
          end
        end
        D_DECODE: begin
          case (cmd_q)
            `OP_ERASE, `OP_DIAG: state_q <= D_MEDIA;
            `OP_FLUSH: begin
              if (CACHE_FLUSH) begin
                state_q <= D_MEDIA;
              end else begin
                link.bsy <= 1'b0;
                state_q <= D_FIN;
              end
            end
            `OP_FORMAT: state_q <= D_SETUP;
            default: begin
              link.bsy <= 1'b0;
              state_q <= D_FIN;
            end
          endcase
        end
        D_SETUP: begin
          // drq raised and bsy dropped together
          if (tmr_done) begin
            link.drq <= 1'b1;
            link.bsy <= 1'b0;
            words_q <= 9'h000;
            state_q <= D_XFER;
          end
        end
        D_XFER: begin
          if (link.data_wr) begin
            words_q <= words_q + 9'h001;
            if (words_q == 9'(`SECTOR_WORDS - 1)) begin
              link.drq <= 1'b0;
              link.bsy <= 1'b1;
              state_q <= D_MEDIA;
            end
          end
        end
        D_MEDIA: begin
          // status only after media reports done
          if (media_done) begin
            link.bsy <= 1'b0;
            state_q <= D_FIN;
          end
        end
        D_FIN: state_q <= D_IDLE;
        default: state_q <= D_IDLE;
      endcase
    end
  end

  // result registers and error bits
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      link.sc_rd <= 8'h00;
      link.err_rd <= 8'h00;
      link.err <= 1'b0;
      link.df <= 1'b0;
      link.drdy <= 1'b1;
      link.dsc <= 1'b1;
    end else if (state_q == D_IDLE && link.cmd_wr) begin
      link.sc_rd <= link.sc;
      link.err <= 1'b0;
      link.df <= 1'b0;
    end else if (state_q == D_DECODE) begin
      case (cmd_q)
        `OP_CHKPWR_A: link.sc_rd <= standby_in ? `SC_STANDBY : `SC_IDLE;
        `OP_ERASE, `OP_DIAG, `OP_FORMAT: link.err <= 1'b0;
        `OP_FLUSH: begin
          if (!CACHE_FLUSH) begin
            link.err <= 1'b1;
            link.err_rd <= `ERR_ABORT;
          end else begin
            // seek flag low until the cache is on the media
            link.dsc <= 1'b0;
          end
        end
        default: begin
          link.err <= 1'b1;
          link.err_rd <= `ERR_ABORT;
        end
      endcase
    end else if (state_q == D_MEDIA && media_done) begin
      case (cmd_q)
        `OP_ERASE: begin
          link.df <= erase_fault_in;
          link.err <= erase_fault_in;
        end
        `OP_DIAG: begin
          link.err_rd <= (!is_slave_in && slave_fail_in) ?
            {`DIAG_SLAVE_NIB, diag_code_in} : {4'h0, diag_code_in};
        end
        `OP_FLUSH: begin
          link.drdy <= 1'b1;
          link.dsc <= 1'b1;
        end
        default: link.df <= 1'b0;
      endcase
    end
  end

  // completion interrupt, one cycle after bsy falls
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      link.intrq <= 1'b0;
    end else if (link.cmd_wr) begin
      link.intrq <= 1'b0;
    end else if (state_q == D_FIN) begin
      // a slave stays quiet after diagnostics
      link.intrq <= !link.irq_disable_bit &&
        !(cmd_q == `OP_DIAG && is_slave_in);
    end
  end

  // media requests, one-cycle pulses with address
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      diag_req_out <= 1'b0;
      erase_req_out <= 1'b0;
      flush_req_out <= 1'b0;
      fmt_req_out <= 1'b0;
      lba_out <= 28'h0000000;
      count_out <= 9'h000;
      fill_out <= 8'h00;
    end else begin
      diag_req_out <= (state_q == D_DECODE) && (cmd_q == `OP_DIAG);
      erase_req_out <= (state_q == D_DECODE) && (cmd_q == `OP_ERASE);
      flush_req_out <= (state_q == D_DECODE) && (cmd_q == `OP_FLUSH) &&
        CACHE_FLUSH;
      fmt_req_out <= (state_q == D_XFER) && link.data_wr &&
        (words_q == 9'(`SECTOR_WORDS - 1));
      if (state_q == D_DECODE && cmd_q == `OP_ERASE) begin
        // 24-bit start, count zero taken as 256
        lba_out <= {4'h0, link.cyl_hi, link.cyl_lo, link.sn};
        count_out <= (link.sc == 8'h00) ? 9'h100 : {1'b0, link.sc};
      end else if (state_q == D_DECODE && cmd_q == `OP_FORMAT) begin
        // head nibble and cylinders, sector unused
        lba_out <= {link.dh[`DH_HEAD_MSB:0], link.cyl_hi, link.cyl_lo,
          8'h00};
        // logical mode count, zero means 256
        if (link.dh[`DH_LBA_BIT]) begin
          count_out <= (link.sc == 8'h00) ? 9'h100 : {1'b0, link.sc};
        end else begin
          count_out <= TRACK_SECTORS;
        end
        fill_out <= FILL;
      end
    end
  end
endmodule

// ==== src/ata_host_end.sv ====
// host controller end: register port in, task-file link out
`timescale 1ns/1ps
`include "ata_params.svh"
module ata_host_end
  import ata_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  ata_link_if.host link,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic irq_out
);
  host_state_t state_q;
  logic [8:0] words_q;
  logic [2:0] wait_q;
  logic seen_bsy_q;
  logic intrq_q;
  logic [`EV_BITS-1:0] int_stat_q;
  logic [`EV_BITS-1:0] int_mask_q;
  logic [`EV_BITS-1:0] ev;
  logic cmd_hit;
  logic done;

  assign cmd_hit = wr_in && (addr_in == `REG_CMD);
  // no bsy at all means the other drive was addressed
  assign done = (state_q == H_WAIT) && !link.bsy && !link.drq &&
    (seen_bsy_q || wait_q == 3'(`HOST_NOBSY_CYC));
  always_comb begin
    ev = '0;
    ev[`EV_DONE] = done;
    ev[`EV_ERROR] = done && link.err;
    // command refused while the host end is not idle or the drive reports bsy
    ev[`EV_REFUSED] = cmd_hit && (state_q != H_IDLE || link.bsy);
    ev[`EV_DEV_IRQ] = link.intrq && !intrq_q;
  end

  // task file registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      link.sc <= 8'h00;
      link.sn <= 8'h00;
      link.cyl_lo <= 8'h00;
      link.cyl_hi <= 8'h00;
      link.dh <= 8'h00;
      link.irq_disable_bit <= 1'b0;
      int_mask_q <= '0;
    end else if (wr_in) begin
      case (addr_in)
        `REG_SC: link.sc <= wdata_in[7:0];
        `REG_SN: link.sn <= wdata_in[7:0];
        `REG_CYL_LO: link.cyl_lo <= wdata_in[7:0];
        `REG_CYL_HI: link.cyl_hi <= wdata_in[7:0];
        `REG_DH: link.dh <= wdata_in[7:0];
        `REG_CTRL: link.irq_disable_bit <= wdata_in[`CTRL_IRQDIS_BIT];
        `REG_INT_MASK: int_mask_q <= wdata_in[`EV_BITS-1:0];
        default: int_mask_q <= int_mask_q;
      endcase
    end
  end

  // command issue and data-out phase
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_q <= H_IDLE;
      link.cmd_wr <= 1'b0;
      link.cmd <= 8'h00;
      link.data_wr <= 1'b0;
      link.data <= 16'h0000;
      words_q <= 9'h000;
      wait_q <= 3'h0;
      seen_bsy_q <= 1'b0;
    end else begin
      link.cmd_wr <= 1'b0;
      link.data_wr <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (cmd_hit && !link.bsy) begin
            link.cmd_wr <= 1'b1;
            link.cmd <= wdata_in[7:0];
            seen_bsy_q <= 1'b0;
            wait_q <= 3'h0;
            state_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (link.bsy) begin
            seen_bsy_q <= 1'b1;
          end else if (wait_q != 3'(`HOST_NOBSY_CYC)) begin
            wait_q <= wait_q + 3'h1;
          end
          if (link.drq) begin
            words_q <= 9'h000;
            state_q <= H_DATA;
          end else if (done) begin
            state_q <= H_IDLE;
          end
        end
        H_DATA: begin
          link.data_wr <= 1'b1;
          link.data <= {7'h00, words_q};
          words_q <= words_q + 9'h001;
          if (words_q == 9'(`SECTOR_WORDS - 1)) begin
            seen_bsy_q <= 1'b0;
            wait_q <= 3'h0;
            state_q <= H_WAIT;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // sticky events, a new event beats a same-cycle clear
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      int_stat_q <= '0;
      intrq_q <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      intrq_q <= link.intrq;
      if (wr_in && addr_in == `REG_INT_STAT) begin
        int_stat_q <= (int_stat_q & ~wdata_in[`EV_BITS-1:0]) | ev;
      end else begin
        int_stat_q <= int_stat_q | ev;
      end
      irq_out <= |(int_stat_q & int_mask_q);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (addr_in)
        `REG_SC: rdata_out <= {24'h000000, link.sc};
        `REG_SN: rdata_out <= {24'h000000, link.sn};
        `REG_CYL_LO: rdata_out <= {24'h000000, link.cyl_lo};
        `REG_CYL_HI: rdata_out <= {24'h000000, link.cyl_hi};
        `REG_DH: rdata_out <= {24'h000000, link.dh};
        `REG_CTRL: rdata_out <= {30'h0, link.irq_disable_bit, 1'b0};
        `REG_STATUS: rdata_out <= {link.err_rd, link.sc_rd, 7'h00,
          state_q != H_IDLE, link.bsy, link.drdy, link.df, link.dsc,
          link.drq, link.intrq, 1'b0, link.err};
        `REG_INT_STAT: rdata_out <= {28'h0, int_stat_q};
        `REG_INT_MASK: rdata_out <= {28'h0, int_mask_q};
        default: rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end
endmodule

// ==== dv/ata_link_checker.sv ====
// concurrent checks on the task-file link between host end and drive end
`timescale 1ns/1ps
`include "ata_params.svh"
module ata_link_checker (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd,
  input wire logic [7:0] dh,
  input wire logic irq_disable_bit,
  input wire logic data_wr,
  input wire logic bsy,
  input wire logic drdy,
  input wire logic dsc,
  input wire logic drq,
  input wire logic err,
  input wire logic intrq,
  input wire logic [7:0] sc_rd
);
  // matches the shortened drq timeout handed to the drive end
  localparam int DRQ_LIM = 64;
  logic [8:0] words_q;
  logic pwr;
  assign pwr = cmd == `OP_CHKPWR_A || cmd == `OP_CHKPWR_B;
  always_ff @(posedge clk_in) begin
    if (!rstn_in || !drq)
      words_q <= '0;
    else if (data_wr)
      words_q <= words_q + 9'd1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_cmd_sets_bsy: assert property (
    cmd_wr && !bsy && (!dh[`DH_DRV_BIT] || cmd == `OP_DIAG) |=> bsy)
    else $error("bsy not raised after command");
  a_irq_after_bsy: assert property (
    $fell(bsy) && !drq && !irq_disable_bit |=> intrq)
    else $error("no interrupt after bsy fell");
  a_irq_disabled: assert property (
    $rose(intrq) |-> !$past(irq_disable_bit))
    else $error("interrupt while disabled");
  a_pwr_count: assert property (
    $fell(bsy) && pwr |-> (sc_rd == `SC_STANDBY || sc_rd == `SC_IDLE) && !err)
    else $error("bad power query count");
  a_drq_bsy_drop: assert property (
    $rose(drq) |-> ##[0:20] !bsy)
    else $error("bsy held after drq");
  a_drq_deadline: assert property (
    cmd_wr && !bsy && !dh[`DH_DRV_BIT] && cmd == `OP_FORMAT
    |-> ##[1:DRQ_LIM] drq)
    else $error("drq late for format");
  a_drq_only_fmt: assert property (
    drq |-> cmd == `OP_FORMAT)
    else $error("data phase outside format");
  a_fmt_words: assert property (
    $fell(drq) |-> words_q == 9'd256)
    else $error("format sector length wrong");
  a_flush_ready: assert property (
    $fell(bsy) && cmd == `OP_FLUSH && !err |-> drdy && dsc)
    else $error("flush done without ready");
  c_format: cover property ($fell(drq));
  c_power: cover property ($fell(bsy) && pwr);
  c_diag: cover property ($fell(bsy) && cmd == `OP_DIAG);
endmodule

// ==== dv/ata_maintenance_command_executor_tb_top.sv ====
// self-checking bench: host end and drive end joined by the link
`timescale 1ns/1ps
`include "ata_params.svh"
module ata_maintenance_command_executor_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr_en = 1'b0, rd_en = 1'b0, standby = 1'b0, slave_fail = 1'b0;
  logic diag_done = 1'b0, erase_done = 1'b0, erase_fault = 1'b0;
  logic flush_done = 1'b0, fmt_done = 1'b0;
  logic [3:0] diag_code = 4'h1;
  logic [31:0] rdata, st;
  logic irq, diag_req, erase_req, flush_req, fmt_req;
  logic [27:0] lba;
  logic [8:0] count;
  logic [7:0] fill;
  wire [3:0] reqs = {fmt_req, flush_req, erase_req, diag_req};
  int n_mismatch = 0, n_checks = 0, n_words = 0, cyc = 0;
  always #10 clk = ~clk;
  ata_link_if u_ata_link_if ();
  ata_host_end u_ata_host_end (.clk_in(clk), .rstn_in(rstn),
    .link(u_ata_link_if.host), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_en), .rd_in(rd_en), .rdata_out(rdata), .irq_out(irq));
  // short drq limit caps the buffer setup at 64 cycles; the 16-cycle setup stays under it
  ata_dev_end #(.DRQ_MAX_CYC(64)) u_ata_dev_end (.clk_in(clk),
    .rstn_in(rstn), .link(u_ata_link_if.dev), .is_slave_in(1'b0),
    .standby_in(standby), .slave_fail_in(slave_fail),
    .diag_done_in(diag_done), .diag_code_in(diag_code),
    .erase_done_in(erase_done), .erase_fault_in(erase_fault),
    .flush_done_in(flush_done), .fmt_done_in(fmt_done),
    .diag_req_out(diag_req), .erase_req_out(erase_req),
    .flush_req_out(flush_req), .fmt_req_out(fmt_req), .lba_out(lba),
    .count_out(count), .fill_out(fill));
  ata_link_checker u_ata_link_checker (.clk_in(clk), .rstn_in(rstn),
    .cmd_wr(u_ata_link_if.cmd_wr), .cmd(u_ata_link_if.cmd),
    .dh(u_ata_link_if.dh), .irq_disable_bit(u_ata_link_if.irq_disable_bit),
    .data_wr(u_ata_link_if.data_wr), .bsy(u_ata_link_if.bsy),
    .drdy(u_ata_link_if.drdy), .dsc(u_ata_link_if.dsc),
    .drq(u_ata_link_if.drq), .err(u_ata_link_if.err),
    .intrq(u_ata_link_if.intrq), .sc_rd(u_ata_link_if.sc_rd));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (u_ata_link_if.data_wr === 1'b1)
      n_words++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %0h", $time, m, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic wait_req(input int k);
    for (int i = 0; i < 2000 && reqs[k] !== 1'b1; i++)
      @(posedge clk) #1;
    chk(reqs[k], 1'b1, "media request missing");
  endtask
  // polls status until neither host nor drive reports busy
  task automatic wait_done();
    st = 32'h180;
    for (int i = 0; i < 300 && st[8:7] !== 2'b00; i++)
      rd(`REG_STATUS, st);
    chk(st[8:7], 2'b00, "command never finished");
  endtask
  task automatic t_power();
    wr(`REG_INT_MASK, 32'h1);
    wr(`REG_DH, 32'h0f);
    for (int i = 0; i < 4; i++) begin
      standby <= i[0];
      wr(`REG_CMD, i[1] ? `OP_CHKPWR_B : `OP_CHKPWR_A);
      wait_done();
      chk(st[23:16], i[0] ? `SC_STANDBY : `SC_IDLE, "pwr");
      rd(`REG_INT_STAT, st);
      chk(st[3], 1'b1, "device interrupt");
      chk(irq, 1'b1, "irq output low");
      wr(`REG_INT_STAT, 32'hf);
      rd(`REG_INT_STAT, st);
      chk(irq, 1'b0, "irq not cleared");
    end
  endtask
  task automatic t_irq_off();
    wr(`REG_INT_MASK, 32'h0);
    wr(`REG_CTRL, 32'h2);
    wr(`REG_CMD, `OP_CHKPWR_A);
    wait_done();
    rd(`REG_INT_STAT, st);
    chk(st[3:0], 4'h1, "interrupt while disabled");
    chk(irq, 1'b0, "masked irq seen");
    wr(`REG_INT_STAT, 32'hf);
    wr(`REG_CTRL, 32'h0);
  endtask
  task automatic t_erase();
    wr(`REG_SN, 32'h11);
    wr(`REG_CYL_LO, 32'h22);
    wr(`REG_CYL_HI, 32'h33);
    wr(`REG_DH, 32'h40);
    for (int i = 0; i < 2; i++) begin
      wr(`REG_SC, i ? 32'h0 : 32'h5);
      wr(`REG_CMD, `OP_ERASE);
      wait_req(1);
      chk(lba[23:0], 24'h332211, "erase start");
      chk(count, i ? 9'd256 : 9'd5, "erase count");
      @(posedge clk);
      erase_done <= 1'b1;
      erase_fault <= i[0];
      @(posedge clk);
      erase_done <= 1'b0;
      wait_done();
      chk({st[5], st[3]}, {i[0], 1'b0}, "erase status");
    end
  endtask
  task automatic t_diag();
    logic [3:0] c;
    // drive bit set on purpose: diagnostics must still run here
    wr(`REG_DH, 32'h10);
    for (int i = 1; i < 7; i++) begin
      c = (i == 6) ? 4'd3 : 4'(i);
      slave_fail <= (i == 6);
      wr(`REG_CMD, `OP_DIAG);
      wait_req(0);
      @(posedge clk);
      diag_done <= 1'b1;
      diag_code <= c;
      @(posedge clk);
      diag_done <= 1'b0;
      wait_done();
      chk(st[31:24], {(i == 6) ? 4'h8 : 4'h0, c}, "diag code");
    end
    slave_fail <= 1'b0;
  endtask
  task automatic t_flush();
    wr(`REG_DH, 32'h0);
    wr(`REG_CMD, `OP_FLUSH);
    wait_req(2);
    // a command written while busy must be refused by the host end
    wr(`REG_CMD, `OP_FLUSH);
    repeat (8) @(posedge clk);
    #1 chk(u_ata_link_if.bsy, 1'b1, "done before commit");
    rd(`REG_STATUS, st);
    chk(st[4], 1'b0, "seek flag set during commit");
    @(posedge clk);
    flush_done <= 1'b1;
    @(posedge clk);
    flush_done <= 1'b0;
    wait_done();
    chk({st[6], st[4], st[0]}, 3'b110, "flush status");
    rd(`REG_INT_STAT, st);
    chk(st[2], 1'b1, "busy command not refused");
    wr(`REG_INT_STAT, 32'hf);
    // unknown opcode takes the same abort path as a missing flush
    wr(`REG_CMD, 32'h0);
    wait_done();
    chk({st[31:24], st[0]}, {`ERR_ABORT, 1'b1}, "abort code");
  endtask
  task automatic t_format();
    wr(`REG_SC, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(`REG_DH, i ? 32'h45 : 32'h03);
      n_words = 0;
      wr(`REG_CMD, `OP_FORMAT);
      wait_req(3);
      chk(count, i ? 9'd256 : `TRACK_SECTORS, "format count");
      chk(lba[27:8], i ? 20'h53322 : 20'h33322, "format start");
      chk(fill, `FILL_PATTERN, "fill pattern");
      chk(n_words, 256, "sector words");
      @(posedge clk);
      fmt_done <= 1'b1;
      @(posedge clk);
      fmt_done <= 1'b0;
      wait_done();
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_power();
    t_irq_off();
    t_erase();
    t_diag();
    t_flush();
    t_format();
    final_report();
  end
endmodule
